// *** verilog/nicr_pkg.sv ***
`default_nettype none
package nicr_pkg;
    // =====================================================================
    // register offsets (register index; byte address is four times it)
    localparam logic [3:0] OFF_CMD = 4'h0;
    localparam logic [3:0] OFF_ADDR_FIRST = 4'h1;
    localparam logic [3:0] OFF_ADDR_LAST = 4'h6;
    localparam logic [3:0] OFF_RX_PAGE = 4'h7;
    localparam logic [3:0] OFF_HASH_FIRST = 4'h8;
    localparam logic [3:0] OFF_RING_START = 4'h1;
    localparam logic [3:0] OFF_RING_STOP = 4'h2;
    localparam logic [3:0] OFF_TX_START = 4'h4;
    localparam logic [3:0] OFF_RXCFG = 4'hC;
    localparam logic [3:0] OFF_TXCFG = 4'hD;
    localparam logic [3:0] OFF_DATACFG = 4'hE;
    localparam logic [3:0] OFF_IRQMASK = 4'hF;
    localparam logic [3:0] OFF_EEPROM = 4'h1;
    localparam logic [3:0] OFF_BOOTPAGE = 4'h2;
    localparam logic [3:0] OFF_JUMPER = 4'h3;
    localparam logic [3:0] OFF_IRQIO = 4'h4;
    localparam logic [3:0] OFF_MEDIUM = 4'h5;
    localparam logic [3:0] OFF_POWER = 4'h6;
    localparam logic [3:0] OFF_CSN = 4'h8;
    localparam logic [3:0] OFF_HALT = 4'h9;
    localparam logic [3:0] OFF_IRQLVL = 4'hB;
    // =====================================================================
    // pages and command register fields
    localparam logic [1:0] PAGE_0 = 2'b00;
    localparam logic [1:0] PAGE_1 = 2'b01;
    localparam logic [1:0] PAGE_2 = 2'b10;
    localparam logic [1:0] PAGE_3 = 2'b11;
    localparam int CMD_PAGE_HI = 7;
    localparam int CMD_PAGE_LO = 6;
    localparam int CMD_RDMA_HI = 5;
    localparam int CMD_RDMA_LO = 3;
    localparam int CMD_TXTRIG = 2;
    localparam int CMD_START = 1;
    localparam int CMD_STOP = 0;
    localparam logic [7:0] CMD_RST = 8'h21;
    typedef enum logic [2:0] {
        NICR_RDMA_BAD = 3'b000,
        NICR_RDMA_READ = 3'b001,
        NICR_RDMA_WRITE = 3'b010,
        NICR_RDMA_SEND = 3'b011,
        NICR_RDMA_ABORT = 3'b100
    } nicr_rdma_e;
    // =====================================================================
    // eeprom control and configuration fields
    localparam int EE_MODE_HI = 7;
    localparam int EE_MODE_LO = 6;
    localparam int EE_CS = 3;
    localparam int EE_SK = 2;
    localparam int EE_DI = 1;
    localparam logic [7:0] EE_WMASK = 8'hCE;
    localparam int CF_IRQEN = 7;
    localparam int CF_PL_HI = 7;
    localparam int CF_PL_LO = 6;
    localparam int CF_BSELB = 5;
    localparam int CF_SLEEP = 2;
    localparam int CF_PWRDN = 1;
    localparam logic [7:0] TXCFG_ONES = 8'hE0;
    localparam logic [7:0] DATACFG_ONES = 8'h80;
    localparam logic [7:0] DATACFG_RST = 8'h04;
    localparam logic [7:0] RXCFG_MASK = 8'h3F;
    localparam logic [7:0] IRQMASK_MASK = 8'h7F;
    // =====================================================================
    // carriers
    typedef struct packed {
        logic jumper;
        logic bnc;
        logic [2:0] irq_sel;
        logic [3:0] io_base;
        logic [4:0] bootrom_size;
        logic pnp;
        logic full_duplex;
        logic [1:0] led_mode;
        logic active_n;
        logic eeprom_do;
        logic [7:0] card_select;
        logic [7:0] irq_lines;
    } nicr_pins_s;
    localparam int PIN_W = $bits(nicr_pins_s);
    typedef struct packed {
        logic eeprom_cs;
        logic eeprom_sk;
        logic eeprom_di;
        logic irq_enable;
        logic [1:0] medium_sel;
        logic bootrom_off;
        logic sleep;
        logic pwrdn;
        logic [7:0] boot_page;
        logic [7:0] clock_halt;
    } nicr_cfg_s;
    typedef struct packed {
        logic [47:0] station_addr;
        logic [63:0] hash_filter;
        logic [7:0] current_rx_page;
    } nicr_filt_s;
    typedef struct packed {
        logic [PIN_W-1:0] sy1;
        logic [PIN_W-1:0] sy2;
        logic [PIN_W-1:0] sy3;
        logic [PIN_W-1:0] pin_q;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] cmd;
        logic dma_start;
        logic dma_abort;
        logic [5:0][7:0] mac_bytes;
        logic [7:0] rx_page;
        logic [7:0][7:0] hash;
        logic [7:0] ring_start;
        logic [7:0] ring_stop;
        logic [7:0] tx_start;
        logic [7:0] rxcfg;
        logic [7:0] txcfg;
        logic [7:0] datacfg;
        logic [7:0] irqmask;
        logic [7:0] ee;
        logic [7:0] rom_page;
        logic irqen;
        logic [1:0] pl;
        logic bselb;
        logic sleep;
        logic pwrdn;
        logic [7:0] hlt;
    } nicr_state_s;
endpackage : nicr_pkg
`default_nettype wire

// *** verilog/nicr_regs.sv ***
// Overview of operation
// [R1] command bits 7:6 choose page: 00, 01, 10, 11 select pages 0-3
// [R2] sixteen byte registers per page, command register at offset 0 on all pages
// [R3] page 1: station address 1-6 low byte first, rx page 7, hash 8-F
// [R4] remote dma field 5:3: read, write, send, top bit set aborts
// [R5] page-3 config 4-6 writable only while both eeprom mode bits are 1
// [R6] start bit only stores, resets 0; stop resets 1 and blocks rx/tx
`timescale 1ns/1ps
`default_nettype none
module nicr_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire nicr_pkg::nicr_pins_s pins,
    input wire logic tx_done,
    output logic [1:0] page_sel,
    output nicr_pkg::nicr_rdma_e rdma_op,
    output logic rdma_start,
    output logic rdma_abort,
    output logic transmit_trigger,
    output logic start_flag,
    output logic stop_flag,
    output logic rx_enable,
    output logic tx_enable,
    output nicr_pkg::nicr_cfg_s cfg,
    output nicr_pkg::nicr_filt_s filt
);
    // =====================================================================
    // helpers
    function automatic nicr_pkg::nicr_rdma_e rdma_decode(input logic [2:0] f);
        if (f[2]) begin
            return nicr_pkg::NICR_RDMA_ABORT;
        end
        return nicr_pkg::nicr_rdma_e'(f);
    endfunction : rdma_decode

    nicr_pkg::nicr_state_s s_r;
    nicr_pkg::nicr_state_s s_nxt;
    nicr_pkg::nicr_pins_s pq;
    logic wr_take;
    logic rd_take;
    logic cfg_wen;
    logic [1:0] page;
    logic [7:0] wd;
    localparam int PIN_EQ_W = nicr_pkg::PIN_W;
    logic [PIN_EQ_W-1:0] eq;

    assign pq = nicr_pkg::nicr_pins_s'(s_r.pin_q);
    // [R1] page select bits
    assign page = {s_r.cmd[nicr_pkg::CMD_PAGE_HI], s_r.cmd[nicr_pkg::CMD_PAGE_LO]};
    assign wd = writedata[7:0];
    // one wait cycle: a request is accepted at the second edge it is seen
    assign waitrequest = (read | write) & ~s_r.ack;
    assign wr_take = write & s_r.ack & byteenable[0];
    assign rd_take = read & ~s_r.ack;
    // [R5] config write gate
    assign cfg_wen = s_r.ee[nicr_pkg::EE_MODE_HI] & s_r.ee[nicr_pkg::EE_MODE_LO];
    assign eq = ~(s_r.sy2 ^ s_r.sy3);

    // =====================================================================
    // next state
    always_comb begin
        logic [7:0] rd;
        rd = 8'h00;
        s_nxt = s_r;
        s_nxt.sy1 = pins;
        s_nxt.sy2 = s_r.sy1;
        s_nxt.sy3 = s_r.sy2;
        // a pin change counts once stages two and three agree
        s_nxt.pin_q = (s_r.sy3 & eq) | (s_r.pin_q & ~eq);
        s_nxt.ack = (read | write) & ~s_r.ack;
        s_nxt.dma_start = 1'b0;
        s_nxt.dma_abort = 1'b0;
        // hardware clear first, so a write in the same cycle wins
        if (tx_done) begin
            s_nxt.cmd[nicr_pkg::CMD_TXTRIG] = 1'b0;
        end
        if (wr_take) begin
            // [R2] command register on every page
            if (address == nicr_pkg::OFF_CMD) begin
                s_nxt.cmd[7:3] = wd[7:3];
                // [R6] start stores, stop gates
                s_nxt.cmd[nicr_pkg::CMD_START] = wd[nicr_pkg::CMD_START];
                s_nxt.cmd[nicr_pkg::CMD_STOP] = wd[nicr_pkg::CMD_STOP];
                // writing 0 to the trigger has no effect; stop blocks sending
                if (wd[nicr_pkg::CMD_TXTRIG] & ~wd[nicr_pkg::CMD_STOP]) begin
                    s_nxt.cmd[nicr_pkg::CMD_TXTRIG] = 1'b1;
                end
                // [R4] remote dma command decode
                if (wd[nicr_pkg::CMD_RDMA_HI]) begin
                    s_nxt.dma_abort = 1'b1;
                end else if (wd[nicr_pkg::CMD_RDMA_HI-1:nicr_pkg::CMD_RDMA_LO] != 2'b00) begin
                    s_nxt.dma_start = 1'b1;
                end
            end else begin
                case (page)
                    nicr_pkg::PAGE_0: begin
                        // write-only setup registers, read back on page 2
                        case (address)
                            nicr_pkg::OFF_RING_START: s_nxt.ring_start = wd;
                            nicr_pkg::OFF_RING_STOP: s_nxt.ring_stop = wd;
                            nicr_pkg::OFF_TX_START: s_nxt.tx_start = wd;
                            nicr_pkg::OFF_RXCFG: s_nxt.rxcfg = wd;
                            nicr_pkg::OFF_TXCFG: s_nxt.txcfg = wd;
                            nicr_pkg::OFF_DATACFG: s_nxt.datacfg = wd;
                            nicr_pkg::OFF_IRQMASK: s_nxt.irqmask = wd;
                            default: ;
                        endcase
                    end
                    nicr_pkg::PAGE_1: begin
                        // [R3] page 1 write map
                        for (int i = 0; i < 6; i++) begin
                            if (address == 4'(i + 1)) begin
                                s_nxt.mac_bytes[i] = wd;
                            end
                        end
                        if (address == nicr_pkg::OFF_RX_PAGE) begin
                            s_nxt.rx_page = wd;
                        end
                        if (address >= nicr_pkg::OFF_HASH_FIRST) begin
                            s_nxt.hash[address[2:0]] = wd;
                        end
                    end
                    nicr_pkg::PAGE_3: begin
                        case (address)
                            nicr_pkg::OFF_EEPROM: s_nxt.ee = wd & nicr_pkg::EE_WMASK;
                            nicr_pkg::OFF_BOOTPAGE: s_nxt.rom_page = wd;
                            nicr_pkg::OFF_HALT: s_nxt.hlt = wd;
                            // [R5] gated config fields
                            nicr_pkg::OFF_IRQIO: begin
                                if (cfg_wen) begin
                                    s_nxt.irqen = wd[nicr_pkg::CF_IRQEN];
                                end
                            end
                            nicr_pkg::OFF_MEDIUM: begin
                                if (cfg_wen) begin
                                    s_nxt.pl = wd[nicr_pkg::CF_PL_HI:nicr_pkg::CF_PL_LO];
                                    s_nxt.bselb = wd[nicr_pkg::CF_BSELB];
                                end
                            end
                            nicr_pkg::OFF_POWER: begin
                                if (cfg_wen) begin
                                    s_nxt.sleep = wd[nicr_pkg::CF_SLEEP];
                                    s_nxt.pwrdn = wd[nicr_pkg::CF_PWRDN];
                                end
                            end
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
        end
        // read mux; page-0 engine status is not part of this block, reads 0
        if (address == nicr_pkg::OFF_CMD) begin
            rd = s_r.cmd;
        end else begin
            case (page)
                nicr_pkg::PAGE_1: begin
                    // [R3] page 1 read map
                    if (address <= nicr_pkg::OFF_ADDR_LAST) begin
                        rd = s_r.mac_bytes[3'(address - nicr_pkg::OFF_ADDR_FIRST)];
                    end else if (address == nicr_pkg::OFF_RX_PAGE) begin
                        rd = s_r.rx_page;
                    end else begin
                        rd = s_r.hash[address[2:0]];
                    end
                end
                nicr_pkg::PAGE_2: begin
                    case (address)
                        nicr_pkg::OFF_RING_START: rd = s_r.ring_start;
                        nicr_pkg::OFF_RING_STOP: rd = s_r.ring_stop;
                        nicr_pkg::OFF_TX_START: rd = s_r.tx_start;
                        nicr_pkg::OFF_RXCFG: rd = s_r.rxcfg & nicr_pkg::RXCFG_MASK;
                        nicr_pkg::OFF_TXCFG: rd = s_r.txcfg | nicr_pkg::TXCFG_ONES;
                        nicr_pkg::OFF_DATACFG: rd = s_r.datacfg | nicr_pkg::DATACFG_ONES;
                        nicr_pkg::OFF_IRQMASK: rd = s_r.irqmask & nicr_pkg::IRQMASK_MASK;
                        default: rd = 8'h00;
                    endcase
                end
                nicr_pkg::PAGE_3: begin
                    case (address)
                        nicr_pkg::OFF_EEPROM: rd = s_r.ee | {7'h00, pq.eeprom_do};
                        nicr_pkg::OFF_BOOTPAGE: rd = s_r.rom_page;
                        nicr_pkg::OFF_JUMPER: rd = {4'h0, pq.jumper, pq.bnc, 2'b00};
                        nicr_pkg::OFF_IRQIO: rd = {s_r.irqen, pq.irq_sel, pq.io_base};
                        nicr_pkg::OFF_MEDIUM: rd = {s_r.pl, s_r.bselb, pq.bootrom_size};
                        nicr_pkg::OFF_POWER: begin
                            rd = {pq.pnp, pq.full_duplex, pq.led_mode, 1'b0,
                                  s_r.sleep, s_r.pwrdn, pq.active_n};
                        end
                        nicr_pkg::OFF_CSN: rd = pq.card_select;
                        nicr_pkg::OFF_IRQLVL: rd = pq.irq_lines;
                        default: rd = 8'h00;
                    endcase
                end
                default: rd = 8'h00;
            endcase
        end
        if (rd_take) begin
            s_nxt.rdata = {24'h00_0000, rd};
        end
    end

    // =====================================================================
    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            // [R6] stop set, start clear at reset
            s_r.cmd <= nicr_pkg::CMD_RST;
            s_r.datacfg <= nicr_pkg::DATACFG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // =====================================================================
    // outputs
    assign readdata = s_r.rdata;
    assign page_sel = page;
    assign rdma_op = rdma_decode(s_r.cmd[nicr_pkg::CMD_RDMA_HI:nicr_pkg::CMD_RDMA_LO]);
    assign rdma_start = s_r.dma_start;
    assign rdma_abort = s_r.dma_abort;
    assign transmit_trigger = s_r.cmd[nicr_pkg::CMD_TXTRIG];
    assign start_flag = s_r.cmd[nicr_pkg::CMD_START];
    assign stop_flag = s_r.cmd[nicr_pkg::CMD_STOP];
    // [R6] stop blocks traffic
    assign rx_enable = ~s_r.cmd[nicr_pkg::CMD_STOP];
    assign tx_enable = ~s_r.cmd[nicr_pkg::CMD_STOP];
    // one driver per output struct, filled field by field
    always_comb begin
        cfg = '0;
        cfg.eeprom_cs = s_r.ee[nicr_pkg::EE_CS];
        cfg.eeprom_sk = s_r.ee[nicr_pkg::EE_SK];
        cfg.eeprom_di = s_r.ee[nicr_pkg::EE_DI];
        cfg.irq_enable = s_r.irqen;
        cfg.medium_sel = s_r.pl;
        cfg.bootrom_off = s_r.bselb;
        cfg.sleep = s_r.sleep;
        cfg.pwrdn = s_r.pwrdn;
        cfg.boot_page = s_r.rom_page;
        cfg.clock_halt = s_r.hlt;
    end

    always_comb begin
        filt = '0;
        filt.station_addr = s_r.mac_bytes;
        filt.hash_filter = s_r.hash;
        filt.current_rx_page = s_r.rx_page;
    end

    // =====================================================================
    // assertions
    default clocking ast_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_PAGE_SEL: assert property ( // [R1]
        wr_take && address == 4'h0 |=> page_sel == $past(writedata[7:6]))
        else $error("page select does not follow command write");
    AST_CMD_READ: assert property ( // [R2]
        rd_take && address == 4'h0 |=> readdata[7:0] == $past(s_r.cmd))
        else $error("command register not readable on this page");
    AST_WAIT_ONE: assert property ( // [R2]
        (read || write) && !s_r.ack |-> waitrequest ##1 !waitrequest)
        else $error("bus answer not after exactly one wait cycle");
    AST_STA_ADDR: assert property ( // [R3]
        wr_take && page == 2'b01 && address == 4'h1
        |=> filt.station_addr[7:0] == $past(writedata[7:0]))
        else $error("first station address byte not stored in low byte");
    AST_HASH_TOP: assert property ( // [R3]
        wr_take && page == 2'b01 && address == 4'hF
        |=> filt.hash_filter[63:56] == $past(writedata[7:0]))
        else $error("last hash byte not stored in filter bits 63:56");
    AST_DMA_ABORT: assert property ( // [R4]
        wr_take && address == 4'h0 && writedata[5]
        |=> rdma_abort && !rdma_start && rdma_op == nicr_pkg::NICR_RDMA_ABORT)
        else $error("remote dma abort not raised");
    AST_CFG_LOCK: assert property ( // [R5]
        wr_take && page == 2'b11 && address == 4'h4 && !cfg_wen
        |=> $stable(cfg.irq_enable))
        else $error("locked configuration field changed");
    AST_START_HOLD: assert property ( // [R6]
        wr_take && address == 4'h0 |=> start_flag == $past(writedata[1]))
        else $error("start bit does not hold written value");
    AST_STOP_BLOCK: assert property ( // [R6]
        stop_flag |-> !rx_enable && !tx_enable && !$rose(transmit_trigger))
        else $error("traffic not blocked while stopped");

    COV_PAGE3: cover property (wr_take && address == 4'h0 && writedata[7:6] == 2'b11);
    COV_CFG_OPEN: cover property (wr_take && page == 2'b11 && address == 4'h5 && cfg_wen);
    COV_SEND: cover property (rdma_start ##[1:20] rdma_abort);
    COV_TX: cover property ($rose(transmit_trigger) ##[1:50] $fell(transmit_trigger));
endmodule : nicr_regs
`default_nettype wire

// *** verification/nicr_strap_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// board straps and the transmit engine that sit around the register bank
module nicr_strap_model #(
    parameter int DONE_DELAY = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic transmit_trigger,
    output var nicr_pkg::nicr_pins_s pins,
    output logic tx_done
);
    int cnt;
    // ==========
    // straps
    // fixed board wiring; every field differs from its neighbours so swaps show
    assign pins = {1'h1, 1'h0, 3'h5, 4'hA, 5'h13, 1'h0, 1'h1, 2'h2, 1'h0, 1'h1, 8'h3C, 8'hA5};
    // ==========
    // transmit engine
    // a frame only goes out while the trigger stands; done is a single-cycle pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            tx_done <= 1'b0;
        end else begin
            tx_done <= 1'b0;
            if (transmit_trigger && !tx_done) begin
                cnt <= cnt + 1;
                if (cnt == DONE_DELAY) begin
                    tx_done <= 1'b1;
                    cnt <= 0;
                end
            end
        end
    end
endmodule : nicr_strap_model
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [1:0] pg;
        logic [3:0] off;
        logic wr;
        logic [7:0] val;
    } nicr_row_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] address = 4'h0;
    logic [3:0] byteenable = 4'h1;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest, tx_done, rdma_start, rdma_abort, transmit_trigger;
    logic start_flag, stop_flag, rx_enable, tx_enable;
    logic [1:0] page_sel;
    nicr_pkg::nicr_pins_s pins;
    nicr_pkg::nicr_rdma_e rdma_op;
    nicr_pkg::nicr_cfg_s cfg;
    nicr_pkg::nicr_filt_s filt;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] q;
    logic [2:0] rc;
    // page, offset, write, data written or value expected on read
    nicr_row_s rows [42] = '{
        '{2'h1, 4'h0, 1'h0, 8'h61}, '{2'h1, 4'h7, 1'h1, 8'h77}, '{2'h1, 4'h8, 1'h1, 8'h88},
        '{2'h1, 4'hF, 1'h1, 8'hFF}, '{2'h1, 4'h7, 1'h0, 8'h77}, '{2'h1, 4'h8, 1'h0, 8'h88},
        '{2'h1, 4'hF, 1'h0, 8'hFF}, '{2'h0, 4'hE, 1'h1, 8'h00}, '{2'h2, 4'hE, 1'h0, 8'h80},
        '{2'h0, 4'hD, 1'h1, 8'h01}, '{2'h2, 4'hD, 1'h0, 8'hE1}, '{2'h0, 4'hC, 1'h1, 8'hFF},
        '{2'h2, 4'hC, 1'h0, 8'h3F}, '{2'h0, 4'h1, 1'h1, 8'h46}, '{2'h2, 4'h1, 1'h0, 8'h46},
        '{2'h0, 4'h4, 1'h1, 8'h40}, '{2'h2, 4'h4, 1'h0, 8'h40}, '{2'h0, 4'hF, 1'h1, 8'hFF},
        '{2'h2, 4'hF, 1'h0, 8'h7F}, '{2'h2, 4'h0, 1'h0, 8'hA1}, '{2'h0, 4'h1, 1'h0, 8'h00},
        '{2'h2, 4'h3, 1'h0, 8'h00}, '{2'h3, 4'h4, 1'h1, 8'h80}, '{2'h3, 4'h4, 1'h0, 8'h5A},
        '{2'h3, 4'h1, 1'h1, 8'hCE}, '{2'h3, 4'h1, 1'h0, 8'hCF}, '{2'h3, 4'h4, 1'h1, 8'h80},
        '{2'h3, 4'h4, 1'h0, 8'hDA}, '{2'h3, 4'h5, 1'h1, 8'hE0}, '{2'h3, 4'h5, 1'h0, 8'hF3},
        '{2'h3, 4'h6, 1'h1, 8'h06}, '{2'h3, 4'h6, 1'h0, 8'h66}, '{2'h3, 4'h3, 1'h0, 8'h08},
        '{2'h3, 4'h8, 1'h0, 8'h3C}, '{2'h3, 4'hB, 1'h0, 8'hA5}, '{2'h3, 4'h2, 1'h1, 8'h5A},
        '{2'h3, 4'h9, 1'h1, 8'h33}, '{2'h3, 4'h9, 1'h0, 8'h00}, '{2'h3, 4'h7, 1'h1, 8'h55},
        '{2'h3, 4'h7, 1'h0, 8'h00}, '{2'h3, 4'hC, 1'h0, 8'h00}, '{2'h3, 4'h0, 1'h0, 8'hE1}
    };

    always #5 clk = ~clk;

    nicr_regs dut (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pins(pins), .tx_done(tx_done), .page_sel(page_sel),
        .rdma_op(rdma_op), .rdma_start(rdma_start), .rdma_abort(rdma_abort),
        .transmit_trigger(transmit_trigger), .start_flag(start_flag), .stop_flag(stop_flag),
        .rx_enable(rx_enable), .tx_enable(tx_enable), .cfg(cfg), .filt(filt));

    nicr_strap_model partner (.clk(clk), .rst_n(rst_n), .transmit_trigger(transmit_trigger),
        .pins(pins), .tx_done(tx_done));

    // ==========
    // helpers
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // holds the request until waitrequest is sampled low; outputs settle 1 ns later
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= wr;
        read <= !wr;
        // waits as long as the slave asks; only the bench timeout ends a hang
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        chk("wait_edges", 64'(2), 64'(n));
        #1;
    endtask : bus

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
    endtask : do_reset

    task automatic chk_reset();
        chk("stop_flag", 64'(1'b1), 64'(stop_flag));
        chk("start_flag", 64'(1'b0), 64'(start_flag));
        chk("rx_enable", 64'(1'b0), 64'(rx_enable));
        chk("tx_enable", 64'(1'b0), 64'(tx_enable));
        chk("page_sel", 64'(2'h0), 64'(page_sel));
        chk("station", 64'(48'h0), 64'(filt.station_addr));
    endtask : chk_reset

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            finish_test();
        end
    end

    // ==========
    // sequence
    initial begin
        do_reset();
        chk_reset();
        for (int i = 0; i < 42; i++) begin
            bus(1'b1, 4'h0, {rows[i].pg, 6'h21}, q);
            chk("page_sel", 64'(rows[i].pg), 64'(page_sel));
            bus(rows[i].wr, rows[i].off, rows[i].val, q);
            if (!rows[i].wr) chk("readdata", 64'(rows[i].val), 64'(q));
        end
        // byte lane off: answered, but the boot page must keep its value
        @(posedge clk);
        byteenable <= 4'h0;
        bus(1'b1, 4'h2, 8'hC3, q);
        @(posedge clk);
        byteenable <= 4'h1;
        chk("cfg", 64'({9'h1FF, 8'h5A, 8'h33}), 64'(cfg));
        chk("hash", 64'hFF00_0000_0000_0088, filt.hash_filter);
        chk("rx_page", 64'(8'h77), 64'(filt.current_rx_page));
        chk("irq_enable", 64'(1'b1), 64'(cfg.irq_enable));
        chk("clock_halt", 64'(8'h33), 64'(cfg.clock_halt));
        bus(1'b1, 4'h0, 8'h61, q);
        for (int i = 1; i <= 6; i++) bus(1'b1, 4'(i), 8'(8'h10 + i), q);
        chk("station", 64'(48'h16_1514_1312_11), 64'(filt.station_addr));
        for (int c = 0; c < 8; c++) begin
            rc = 3'(c);
            bus(1'b1, 4'h0, {2'h0, rc, 3'h1}, q);
            chk("rdma_op", 64'(rc[2] ? 3'h4 : rc), 64'(rdma_op));
            chk("rdma_start", 64'(rc != 3'h0 && !rc[2]), 64'(rdma_start));
            chk("rdma_abort", 64'(rc[2]), 64'(rdma_abort));
        end
        // trigger together with stop must not launch a frame
        bus(1'b1, 4'h0, 8'h25, q);
        chk("trigger", 64'(1'b0), 64'(transmit_trigger));
        bus(1'b1, 4'h0, 8'h26, q);
        chk("start_flag", 64'(1'b1), 64'(start_flag));
        chk("rx_enable", 64'(1'b1), 64'(rx_enable));
        chk("trigger", 64'(1'b1), 64'(transmit_trigger));
        for (int n = 0; n < 20 && transmit_trigger === 1'b1; n++) @(posedge clk);
        #1;
        chk("trigger", 64'(1'b0), 64'(transmit_trigger));
        bus(1'b1, 4'h0, 8'h23, q);
        chk("tx_enable", 64'(1'b0), 64'(tx_enable));
        chk("start_flag", 64'(1'b1), 64'(start_flag));
        do_reset();
        chk_reset();
        bus(1'b0, 4'h0, 8'h00, q);
        chk("command", 64'(8'h21), 64'(q));
        finish_test();
    end
endmodule : testbench
`default_nettype wire
